//--- verilog/srf_pkg.sv
// constants and types shared by the supervisor reset / two-wire slave front end.
// assumes a single 50 MHz system clock.
package srf_pkg;

    // system clock
    localparam longint CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;

    // reset timeout, nominal, in ms (window 130..270 ms)
    localparam longint RST_TIMEOUT_MS = 200;
    localparam int RST_CYC = int'(RST_TIMEOUT_MS * CLK_HZ / 64'd1000);

    // internal programming cycle, longest, in ms
    localparam longint PROG_TIME_MS = 5;
    localparam int PROG_CYC = int'(PROG_TIME_MS * CLK_HZ / 64'd1000);

    // manual reset glitch immunity, in ns; least time, rounded up
    localparam int MR_GLITCH_NS = 100;
    localparam int MR_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // slave address byte layout
    localparam logic [3:0] DEV_CODE_DEF = 4'ha;
    localparam int ADDR_CODE_MSB = 7;
    localparam int ADDR_CODE_LSB = 4;
    localparam int ADDR_RW_BIT = 0;
    localparam logic RW_READ = 1'h1;

    // write stream word: {first byte marker, data}
    localparam int WR_WORD_W = 9;
    localparam int FIFO_DEPTH = 4;

    // bus states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_RX = 3'h2,
        ST_RACK = 3'h6,
        ST_TX = 3'h7,
        ST_MACK = 3'h5,
        ST_WAIT = 3'h4
    } srf_state_e;

endpackage : srf_pkg

//--- verilog/srf_fifo.sv
// small flip-flop fifo with valid/ready on both sides.
// assumes both sides on the same clock; depth is a power of two.
`timescale 1ns/1ps
module srf_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    logic [AW:0] cnt_next;

    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign o_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            o_ready <= 1'b1;
            o_valid <= 1'b0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            cnt_reg <= cnt_next;
            // flags kept as flops so both handshakes are glitch free
            o_ready <= (cnt_next != (AW+1)'(D));
            o_valid <= (cnt_next != '0);
        end
    end
endmodule : srf_fifo

//--- verilog/srf_front.sv
// supply supervisor reset sequencer with the two-wire slave front end of a
// small nonvolatile memory. received bytes leave through a 4-word fifo.
// assumes pins arrive asynchronous; the memory array sits outside.
//
// Contract
// - reset held while supply below threshold, then for the timeout
// - after the timeout, reset outputs are released to the pull resistors
// - reset asserts as soon as supply falls below threshold
// - falling edge on the reset pin starts a new timeout
// - short external reset pulls still give a full timeout
// - manual reset low asserts reset, held for timeout after release
// - manual reset low pulses under 100 ns are ignored
// - reset aborts serial transfers and refuses new ones
// - no program cycle starts in reset; a running one completes
// - write protect high blocks every array write
// - start is data falling with clock high; idle until one
// - stop is data rising with clock high; it ends every operation
// - data changes only with clock low; else it is start or stop
// - upper four address bits compared against the device code
// - last address bit: 1 read, 0 write
// - matching address is acknowledged, then read or write follows
// - receiver acknowledges each byte by pulling data low on ninth clock
// - each written byte is acknowledged; here a full fifo, or write protect after the first byte, gives no acknowledge
// - read sends 8 bits, releases data, samples master acknowledge
// - master not acknowledging ends sending; wait for stop
// - reset timeout lies between 130 and 270 ms
// - during programming the address is not acknowledged
`timescale 1ns/1ps
module srf_front #(
    parameter int RST_CYC = srf_pkg::RST_CYC,
    parameter int PROG_CYC = srf_pkg::PROG_CYC,
    parameter logic [3:0] DEV_CODE = srf_pkg::DEV_CODE_DEF,
    parameter int FIFO_DEPTH = srf_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // supervisor inputs
    input wire logic i_supply_ok,
    input wire logic i_manual_reset_n_input,
    input wire logic i_write_protect,
    // active low reset pin, open drain, also an input
    input wire logic i_reset_n_pin,
    output logic o_reset_n_o,
    output logic o_reset_n_oe,
    // active high reset pin, open drain to high
    output logic o_reset_hi_o,
    output logic o_reset_hi_oe,
    // two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // received write stream
    output logic o_wr_valid,
    output logic [srf_pkg::WR_WORD_W-1:0] o_wr_data,
    input wire logic i_wr_ready,
    // read data from the array
    input wire logic [7:0] i_rd_data,
    output logic o_rd_next,
    // programming cycle and reset status
    output logic o_prog_start,
    output logic o_prog_busy,
    output logic o_reset_active
);
    localparam int RW = $clog2(RST_CYC + 1);
    localparam int PW = $clog2(PROG_CYC + 1);
    localparam int MW = $clog2(srf_pkg::MR_CYC + 1);

    // pin synchronisers: {wp, mr, pin, supply, sda, scl}
    logic [5:0] meta_reg;
    logic [5:0] sync_reg;
    logic scl_s, sda_s, sup_s, pin_s, mr_s, wp_s;
    logic scl_d_reg, sda_d_reg, pin_d_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // idle levels: bus lines and reset pins high, supply low, no protect
            meta_reg <= 6'h1b;
            sync_reg <= 6'h1b;
        end else begin
            meta_reg <= {i_write_protect, i_manual_reset_n_input, i_reset_n_pin,
                         i_supply_ok, i_sda, i_scl};
            sync_reg <= meta_reg;
        end
    end

    assign {wp_s, mr_s, pin_s, sup_s, sda_s, scl_s} = sync_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            pin_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            pin_d_reg <= pin_s;
        end
    end

    // manual reset glitch filter
    logic [MW-1:0] mr_cnt_reg;
    logic mr_low_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mr_cnt_reg <= '0;
            mr_low_reg <= 1'b0;
        end else if (mr_s) begin
            mr_cnt_reg <= '0;
            mr_low_reg <= 1'b0;
        end else if (mr_cnt_reg == MW'(srf_pkg::MR_CYC - 1)) begin
            mr_low_reg <= 1'b1;
        end else begin
            mr_cnt_reg <= mr_cnt_reg + 1'b1;
        end
    end

    mr_glitch_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(mr_low_reg) |-> $past(mr_cnt_reg) == MW'(srf_pkg::MR_CYC - 1))
        else $error("manual reset accepted before glitch time");

    // reset timer
    logic [RW-1:0] rst_tmr_reg;
    logic rst_active_reg;
    logic pin_fall;
    logic rst_hold;
    logic [RW-1:0] rst_tmr_next;

    // our own drive pulls the pin low too, so only foreign falls count
    assign pin_fall = pin_d_reg && !pin_s && !o_reset_n_oe;
    assign rst_hold = !sup_s || mr_low_reg;

    always_comb begin
        rst_tmr_next = rst_tmr_reg;
        if (rst_hold || pin_fall) begin
            rst_tmr_next = RW'(RST_CYC);
        end else if (rst_tmr_reg != '0) begin
            rst_tmr_next = rst_tmr_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_tmr_reg <= RW'(RST_CYC);
            rst_active_reg <= 1'b1;
        end else begin
            rst_tmr_reg <= rst_tmr_next;
            rst_active_reg <= rst_hold || pin_fall || (rst_tmr_next != '0);
        end
    end

    // open-drain reset pins; both enables follow one flag
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reset_n_o <= 1'b0;
            o_reset_n_oe <= 1'b1;
            o_reset_hi_o <= 1'b1;
            o_reset_hi_oe <= 1'b1;
            o_reset_active <= 1'b1;
        end else begin
            o_reset_n_o <= 1'b0;
            o_reset_hi_o <= 1'b1;
            o_reset_n_oe <= rst_active_reg;
            o_reset_hi_oe <= rst_active_reg;
            o_reset_active <= rst_active_reg;
        end
    end

    supply_low_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !sup_s |=> ##1 o_reset_n_oe)
        else $error("reset not driven after supply drop");

    timeout_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (rst_tmr_reg != '0) |=> o_reset_n_oe)
        else $error("reset released while timeout runs");

    release_drive_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (rst_tmr_reg == '0 && !rst_hold && !pin_fall) |=> ##1 !o_reset_n_oe)
        else $error("reset still driven after timeout");

    pin_edge_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pin_fall |=> rst_tmr_reg == RW'(RST_CYC))
        else $error("pin fall did not restart timeout");

    high_mirror_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_reset_hi_oe == o_reset_n_oe)
        else $error("reset outputs disagree");

    // program cycle timer
    logic [PW-1:0] prog_tmr_reg;
    logic wr_pend_reg;
    logic prog_go;
    logic start_det;
    logic stop_det;

    // a running cycle is not cut short by reset
    assign prog_go = stop_det && wr_pend_reg && !rst_active_reg && !o_prog_busy
                     && !wp_s;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prog_tmr_reg <= '0;
            o_prog_busy <= 1'b0;
            o_prog_start <= 1'b0;
        end else begin
            o_prog_start <= prog_go;
            if (prog_go) begin
                prog_tmr_reg <= PW'(PROG_CYC);
                o_prog_busy <= 1'b1;
            end else if (prog_tmr_reg != '0) begin
                prog_tmr_reg <= prog_tmr_reg - 1'b1;
                o_prog_busy <= (prog_tmr_reg != PW'(1));
            end
        end
    end

    prog_gate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_prog_start |-> !$past(rst_active_reg) && !$past(wp_s))
        else $error("program cycle started in reset or write protect");

    // bus condition detection
    logic scl_rise;
    logic scl_fall;

    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;

    // byte engine
    srf_pkg::srf_state_e st_reg;
    logic [7:0] sh_reg;
    logic [3:0] bit_reg;
    logic first_reg;
    logic mack_reg;
    logic fifo_ready;
    logic push_reg;
    logic [srf_pkg::WR_WORD_W-1:0] push_data_reg;
    logic byte_ok;
    logic addr_ok;

    // a byte is taken only with fifo room; a full fifo answers with no acknowledge
    assign byte_ok = fifo_ready && !(wp_s && !first_reg);
    assign addr_ok = sh_reg[srf_pkg::ADDR_CODE_MSB:srf_pkg::ADDR_CODE_LSB] == DEV_CODE
                     && !o_prog_busy;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= srf_pkg::ST_IDLE;
            sh_reg <= '0;
            bit_reg <= '0;
            first_reg <= 1'b1;
            mack_reg <= 1'b0;
            o_sda_o <= 1'b0;
            o_sda_oe <= 1'b0;
            o_rd_next <= 1'b0;
            push_reg <= 1'b0;
            push_data_reg <= '0;
        end else begin
            o_sda_o <= 1'b0;
            o_rd_next <= 1'b0;
            push_reg <= 1'b0;
            if (rst_active_reg) begin
                st_reg <= srf_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (stop_det) begin
                st_reg <= srf_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (start_det) begin
                st_reg <= srf_pkg::ST_ADDR;
                bit_reg <= '0;
                first_reg <= 1'b1;
                o_sda_oe <= 1'b0;
            end else begin
                case (st_reg)
                    srf_pkg::ST_ADDR, srf_pkg::ST_RX: begin
                        if (scl_rise) begin
                            sh_reg <= {sh_reg[6:0], sda_s};
                            bit_reg <= bit_reg + 1'b1;
                        end else if (scl_fall && bit_reg == 4'h8) begin
                            bit_reg <= '0;
                            if (st_reg == srf_pkg::ST_ADDR) begin
                                st_reg <= addr_ok ? srf_pkg::ST_AACK : srf_pkg::ST_WAIT;
                                o_sda_oe <= addr_ok;
                                mack_reg <= sh_reg[srf_pkg::ADDR_RW_BIT];
                            end else if (byte_ok) begin
                                st_reg <= srf_pkg::ST_RACK;
                                o_sda_oe <= 1'b1;
                                push_reg <= 1'b1;
                                push_data_reg <= {first_reg, sh_reg};
                                first_reg <= 1'b0;
                            end else begin
                                st_reg <= srf_pkg::ST_WAIT;
                            end
                        end
                    end
                    srf_pkg::ST_AACK: begin
                        if (scl_fall) begin
                            if (mack_reg == srf_pkg::RW_READ) begin
                                st_reg <= srf_pkg::ST_TX;
                                sh_reg <= {i_rd_data[6:0], 1'b0};
                                o_sda_oe <= !i_rd_data[7];
                                o_rd_next <= 1'b1;
                            end else begin
                                st_reg <= srf_pkg::ST_RX;
                                o_sda_oe <= 1'b0;
                            end
                        end
                    end
                    srf_pkg::ST_RACK: begin
                        if (scl_fall) begin
                            st_reg <= srf_pkg::ST_RX;
                            o_sda_oe <= 1'b0;
                        end
                    end
                    srf_pkg::ST_TX: begin
                        if (scl_fall) begin
                            if (bit_reg == 4'h7) begin
                                st_reg <= srf_pkg::ST_MACK;
                                o_sda_oe <= 1'b0;
                                bit_reg <= '0;
                            end else begin
                                o_sda_oe <= !sh_reg[7];
                                sh_reg <= {sh_reg[6:0], 1'b0};
                                bit_reg <= bit_reg + 1'b1;
                            end
                        end
                    end
                    srf_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            mack_reg <= !sda_s;
                        end else if (scl_fall) begin
                            if (mack_reg) begin
                                st_reg <= srf_pkg::ST_TX;
                                sh_reg <= {i_rd_data[6:0], 1'b0};
                                o_sda_oe <= !i_rd_data[7];
                                o_rd_next <= 1'b1;
                            end else begin
                                st_reg <= srf_pkg::ST_WAIT;
                            end
                        end
                    end
                    default: begin
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // a stop programs only if data bytes followed the word address
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_reg <= 1'b0;
        end else if (rst_active_reg || stop_det || start_det) begin
            wr_pend_reg <= 1'b0;
        end else if (push_reg && !push_data_reg[8] && !wp_s) begin
            wr_pend_reg <= 1'b1;
        end
    end

    srf_fifo #(
        .W(srf_pkg::WR_WORD_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(push_reg),
        .i_data(push_data_reg),
        .o_ready(fifo_ready),
        .o_valid(o_wr_valid),
        .o_data(o_wr_data),
        .i_ready(i_wr_ready)
    );

    reset_abort_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        rst_active_reg |=> st_reg == srf_pkg::ST_IDLE && !o_sda_oe)
        else $error("bus not idle during reset");

    start_seen_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (start_det && !stop_det && !rst_active_reg) |=> st_reg == srf_pkg::ST_ADDR)
        else $error("start not recognised");

    stop_seen_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        stop_det |=> st_reg == srf_pkg::ST_IDLE)
        else $error("stop not recognised");

    addr_ack_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_reg == srf_pkg::ST_AACK || st_reg == srf_pkg::ST_RACK) |-> o_sda_oe)
        else $error("acknowledge not driven");

    busy_nack_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_reg == srf_pkg::ST_ADDR && o_prog_busy) |=> st_reg != srf_pkg::ST_AACK)
        else $error("address acknowledged while programming");

endmodule : srf_front

//--- tb/srf_master.sv
// two-wire bus master model: clock and data, low side only.
// assumes pull-ups on both wires; a quarter bit is two system clocks.
`timescale 1ns/1ps
module srf_master (
    // clock
    input wire logic i_clk,
    // wire level and drives
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // both lines rest high between frames
    initial begin
        o_scl = 1'h1;
        o_sda = 1'h1;
    end
    task automatic qt();
        repeat (2) @(posedge i_clk);
    endtask : qt
    // entered with the bus idle or after a bit, so a repeat start works too
    task automatic start();
        qt();
        o_sda <= 1'h1;
        qt();
        o_scl <= 1'h1;
        qt();
        o_sda <= 1'h0;
        qt();
        o_scl <= 1'h0;
    endtask : start
    task automatic bit_io(input logic b, output logic r);
        qt();
        o_sda <= b;
        qt();
        o_scl <= 1'h1;
        qt();
        r = i_sda;
        qt();
        o_scl <= 1'h0;
    endtask : bit_io
    task automatic stop();
        qt();
        o_sda <= 1'h0;
        qt();
        o_scl <= 1'h1;
        qt();
        o_sda <= 1'h1;
        qt();
    endtask : stop
    // last=1 releases the ninth bit, last=0 acknowledges a read byte
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(last, a);
        ack = ~a;
    endtask : xfer
endmodule : srf_master

//--- tb/srf_front_tb.sv
// self-checking bench for the supervisor reset and two-wire slave front end.
// assumes the master model; timers shortened so the run stays short.
`timescale 1ns/1ps
module srf_front_tb;
    localparam int RCYC = 200;
    localparam int PCYC = 100;
    logic i_clk, i_arst_n, supply_ok, mr_n, wp, ext_n, wr_ready;
    logic [7:0] rd_data;
    logic m_scl, m_sda, sda, pin_n;
    logic rst_o, rst_oe, hi_o, hi_oe, sda_o, sda_oe, wr_valid;
    logic rd_next, prog_start, prog_busy, rst_act;
    logic [8:0] wr_data;
    logic [8:0] q[$];
    int n_errors, samples_checked, cyc, n_prog, n_rdn, t0, k;
    // wired-and of open-drain drivers over pull-ups
    assign sda = (sda_oe ? sda_o : 1'h1) & m_sda;
    assign pin_n = (rst_oe ? rst_o : 1'h1) & ext_n;
    srf_front #(.RST_CYC(RCYC), .PROG_CYC(PCYC)) uut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_supply_ok(supply_ok),
        .i_manual_reset_n_input(mr_n), .i_write_protect(wp), .i_reset_n_pin(pin_n),
        .o_reset_n_o(rst_o), .o_reset_n_oe(rst_oe), .o_reset_hi_o(hi_o),
        .o_reset_hi_oe(hi_oe), .i_scl(m_scl), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .o_wr_valid(wr_valid), .o_wr_data(wr_data),
        .i_wr_ready(wr_ready), .i_rd_data(rd_data), .o_rd_next(rd_next),
        .o_prog_start(prog_start), .o_prog_busy(prog_busy), .o_reset_active(rst_act));
    srf_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
    initial begin
        i_clk = 1'h0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        n_prog += (prog_start === 1'h1);
        n_rdn += (rd_next === 1'h1);
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // model: acks and fifo words follow from fill level and write protect
    task automatic wr_txn(input logic [7:0] a, input int n, input logic exp_a);
        logic [7:0] r, b;
        logic ack, e;
        m.start();
        m.xfer(a, 1'h1, r, ack);
        chk(ack, exp_a);
        for (int i = 0; i <= n && ack === 1'h1; i++) begin
            b = $urandom;
            e = q.size() < 4 && (i == 0 || !wp);
            m.xfer(b, 1'h1, r, ack);
            chk(ack, e);
            if (e) q.push_back({i == 0, b});
        end
        m.stop();
        repeat (6) @(posedge i_clk);
    endtask : wr_txn
    task automatic rd_txn(input int n);
        logic [7:0] r, e;
        logic ack;
        k = n_rdn;
        m.start();
        m.xfer(8'ha1, 1'h1, r, ack);
        chk(ack, 1'h1);
        for (int i = 0; i < n; i++) begin
            e = $urandom;
            rd_data <= e;
            m.xfer(8'hff, i == n - 1, r, ack);
            chk(r, e);
        end
        chk(n_rdn - k, n);
        // after the missing acknowledge the line must stay released
        m.xfer(8'hff, 1'h1, r, ack);
        chk({ack, r}, 9'h0ff);
        m.stop();
    endtask : rd_txn
    task automatic drain();
        k = 0;
        while (q.size() > 0 && k < 300) begin
            @(posedge i_clk);
            k++;
            if (wr_valid === 1'h1 && wr_ready === 1'h1) chk(wr_data, q.pop_front());
            wr_ready <= q.size() > 0 ? 1'($urandom) : 1'h0;
        end
        repeat (2) @(posedge i_clk);
        chk({wr_valid, 8'(q.size())}, 9'h000);
    endtask : drain
    task automatic rel(input int lo);
        k = 0;
        while (rst_act === 1'h1 && k < 3000) begin
            @(posedge i_clk);
            k++;
        end
        chk(cyc - t0 >= lo && cyc - t0 <= lo + 10, 1'h1);
        chk({rst_oe, hi_oe, hi_o, rst_o}, 4'h2);
    endtask : rel
    task automatic busy_lo();
        k = 0;
        while (prog_busy === 1'h1 && k < 500) begin
            @(posedge i_clk);
            k++;
        end
        // a cycle that never ends counts as a mismatch
        chk(prog_busy, 1'h0);
    endtask : busy_lo
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        {i_arst_n, supply_ok, wp, wr_ready} = 4'h0;
        {mr_n, ext_n} = 2'h3;
        rd_data = 8'h00;
        void'($urandom(32'h454a));
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'h1;
        repeat (20) @(posedge i_clk);
        chk({rst_act, rst_oe, hi_oe}, 3'h7);
        supply_ok <= 1'h1;
        t0 = cyc;
        wr_txn(8'ha0, 1, 1'h0);
        rel(RCYC);
        // host traffic is acknowledged only after the reset window
        wr_txn(8'ha0, 2, 1'h1);
        chk(n_prog, 1);
        wr_txn(8'ha0, 0, 1'h0);
        drain();
        busy_lo();
        wr_txn(8'ha0, 4, 1'h1);
        drain();
        busy_lo();
        for (int i = 0; i < 3; i++) begin
            wr_txn({4'($urandom_range(0, 9)), 3'h0, 1'($urandom)}, 0, 1'h0);
        end
        rd_txn(3);
        wp <= 1'h1;
        t0 = n_prog;
        wr_txn(8'ha0, 1, 1'h1);
        chk(n_prog - t0, 0);
        wp <= 1'h0;
        drain();
        mr_n <= 1'h0;
        repeat (3) @(posedge i_clk);
        mr_n <= 1'h1;
        repeat (10) @(posedge i_clk);
        chk(rst_act, 1'h0);
        mr_n <= 1'h0;
        repeat (20) @(posedge i_clk);
        chk({rst_act, rst_oe, hi_oe}, 3'h7);
        mr_n <= 1'h1;
        t0 = cyc;
        rel(RCYC);
        ext_n <= 1'h0;
        repeat (2) @(posedge i_clk);
        ext_n <= 1'h1;
        t0 = cyc - 2;
        repeat (8) @(posedge i_clk);
        chk(rst_act, 1'h1);
        rel(RCYC);
        wr_txn(8'ha0, 1, 1'h1);
        chk(prog_busy, 1'h1);
        supply_ok <= 1'h0;
        t0 = cyc;
        repeat (6) @(posedge i_clk);
        chk(rst_act, 1'h1);
        busy_lo();
        chk(cyc - t0 >= PCYC - 20 && cyc - t0 <= PCYC, 1'h1);
        supply_ok <= 1'h1;
        t0 = cyc;
        rel(RCYC);
        drain();
        complete_run();
    end
endmodule : srf_front_tb
